// ==== rtl/qss_pkg.sv ====
package qss_pkg;
  // ****************************************
  // Queue geometry
  // ****************************************
  localparam int ENTRIES = 16;
  localparam int PTR_W = 4;
  localparam int WORD_W = 16;
  localparam int CMD_W = 8;
  localparam int LEN_W = 5;
  localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
  localparam logic [PTR_W-1:0] PTR_STEP = 4'h1;
  // ****************************************
  // Command byte layout
  // ****************************************
  localparam int CMD_PCS_LSB = 0;
  localparam int CMD_PCS_W = 4;
  localparam int CMD_BITSE_BIT = 6;
  localparam int CMD_CONT_BIT = 7;
  // ****************************************
  // Transfer length and clock divider
  // ****************************************
  localparam int BITS_FIELD_W = 4;
  localparam logic [LEN_W-1:0] LEN_DEFAULT = 5'h08;
  localparam logic [LEN_W-1:0] LEN_MAX = 5'h10;
  localparam logic [BITS_FIELD_W-1:0] BITS_FIELD_MIN = 4'h8;
  localparam logic [7:0] DIV_MIN = 8'h02;
  localparam logic [7:0] DIV_STEP = 8'h01;
  // ****************************************
  // Memory write segments
  // ****************************************
  localparam logic SEG_CMD = 1'h0;
  localparam logic SEG_TX = 1'h1;
  // ****************************************
  // Pin positions
  // ****************************************
  localparam int PIN_N = 7;
  localparam int PIN_MISO = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_SCK = 2;
  localparam int PIN_PERIPH_SELECT_ZERO = 3;
  localparam int PIN_PCS_UP = 4;
  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_LOAD, ST_XFER, ST_STORE, ST_HALT} qss_state_t;
endpackage : qss_pkg

// ==== rtl/qss_fifo.sv ====
`timescale 1ns/1ns
module qss_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push = i_in_valid && !full;
  wire pop = i_out_ready && !empty;
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= i_in_data;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
  chk_fifo_full_block: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    full && !pop |=> $stable(wr_q))
    else $error("fifo write pointer moved while full");
endmodule : qss_fifo

// ==== rtl/qss_top.sv ====
// Function
// - Transmit words are only copied into the shifter, never modified.
// - Sixteen command bytes, written by software, only read by the sequencer.
// - Command byte splits into chip-select pattern and transfer option fields.
// - Sixteen entries, each a command byte, a transmit word and a receive word.
// - Queue runs from start pointer through end pointer, sixteen commands at most.
// - Seven pins, each usable as general-purpose I/O when not serial.
// - Master drives data-out and clock, reads data-in; slave the reverse.
// - Select input asserted in master mode sets the mode-fault flag.
// - Mode fault keeps master select and drivers; only disable stops the port.
// - When enabled, run the queue, then set the done flag and wait.
// - Start, end, completed pointers visible; the working pointer is internal.
// - Working pointer loads from start, copies into completed, then increments.
// - After each command compare end and completed; match sets done, halts.
// - Reset clears the start and end pointers to entry zero.
// - New start updates the working pointer after the running transfer ends.
// - Start and end both zero gives exactly one transfer.
// - Master select chooses master or slave operation.
// - Master drives command chip selects, sends transmit, stores receive data.
// - Slave starts the next queued transfer on select; no chip selects driven.
// - Received data right-justified, unused upper bits zero.
// - Pointer writes are buffered until the current transfer ends; reads show active.
// - With wrap enabled, continue from entry zero or start per wrap target.
`timescale 1ns/1ns
module qss_top #(
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Control bits
  input wire logic i_port_enable_bit,
  input wire logic i_master_select_bit,
  input wire logic i_wrap_enable_bit,
  input wire logic i_wrap_target_bit,
  input wire logic i_periph_select_zero_is_output,
  input wire logic [qss_pkg::BITS_FIELD_W-1:0] i_bits_field,
  input wire logic [7:0] i_baud_div,
  // Queue pointer write
  input wire logic i_ptr_wr,
  input wire logic [qss_pkg::PTR_W-1:0] i_queue_start_pointer,
  input wire logic [qss_pkg::PTR_W-1:0] i_queue_end_pointer,
  // Status clear strobes
  input wire logic i_clr_done,
  input wire logic i_clr_fault,
  // Memory write port (command and transmit segments)
  input wire logic i_mem_we,
  input wire logic i_mem_seg,
  input wire logic [qss_pkg::PTR_W-1:0] i_mem_idx,
  input wire logic [qss_pkg::WORD_W-1:0] i_mem_wdata,
  // Receive memory read port
  input wire logic i_rx_rd_en,
  input wire logic [qss_pkg::PTR_W-1:0] i_rx_rd_idx,
  output logic [qss_pkg::WORD_W-1:0] o_rx_rdata,
  // Status
  output logic o_queue_done_flag,
  output logic o_mode_fault_flag,
  output logic [qss_pkg::PTR_W-1:0] o_completed_entry_pointer,
  output logic [qss_pkg::PTR_W-1:0] o_active_start_pointer,
  output logic [qss_pkg::PTR_W-1:0] o_active_end_pointer,
  output logic o_busy,
  // Pins and general-purpose I/O
  input wire logic [qss_pkg::PIN_N-1:0] i_pin_in,
  input wire logic [qss_pkg::PIN_N-1:0] i_gpio_out,
  input wire logic [qss_pkg::PIN_N-1:0] i_gpio_dir,
  output logic [qss_pkg::PIN_N-1:0] o_pin_out,
  output logic [qss_pkg::PIN_N-1:0] o_pin_oe,
  output logic [qss_pkg::PIN_N-1:0] o_gpio_in
);
  localparam int PW = qss_pkg::PTR_W;
  localparam int WW = qss_pkg::WORD_W;
  localparam int LW = qss_pkg::LEN_W;
  localparam int FW = PW + WW;

  function automatic logic [LW-1:0] len_of(input logic use_field,
                                           input logic [qss_pkg::BITS_FIELD_W-1:0] f);
    // Reserved field codes fall back to the default length
    if (!use_field) begin
      len_of = qss_pkg::LEN_DEFAULT;
    end else if (f == '0) begin
      len_of = qss_pkg::LEN_MAX;
    end else if (f < qss_pkg::BITS_FIELD_MIN) begin
      len_of = qss_pkg::LEN_DEFAULT;
    end else begin
      len_of = {1'b0, f};
    end
  endfunction : len_of

  // ****************************************
  // Shared memory
  // ****************************************
  logic [qss_pkg::CMD_W-1:0] cmd_mem_q [qss_pkg::ENTRIES];
  logic [WW-1:0] tx_mem_q [qss_pkg::ENTRIES];
  logic [WW-1:0] rx_mem_q [qss_pkg::ENTRIES];
  logic [WW-1:0] rx_rdata_q;
  wire fifo_out_valid;
  wire [FW-1:0] fifo_out_data;
  // CPU reads own the receive array; the drain waits, so the fifo can really fill
  wire fifo_out_ready = !i_rx_rd_en;
  wire rx_store = fifo_out_valid && fifo_out_ready;

  always_ff @(posedge i_sys_clk) begin
    if (i_mem_we && i_mem_seg == qss_pkg::SEG_CMD) begin
      cmd_mem_q[i_mem_idx] <= i_mem_wdata[qss_pkg::CMD_W-1:0];
    end
    if (i_mem_we && i_mem_seg == qss_pkg::SEG_TX) begin
      tx_mem_q[i_mem_idx] <= i_mem_wdata;
    end
    if (rx_store) begin
      rx_mem_q[fifo_out_data[FW-1:WW]] <= fifo_out_data[WW-1:0];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_rdata_q <= '0;
    end else if (i_rx_rd_en) begin
      rx_rdata_q <= rx_mem_q[i_rx_rd_idx];
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [qss_pkg::PIN_N-1:0] pin_meta_q;
  logic [qss_pkg::PIN_N-1:0] pin_sync_q;
  logic sck_prev_q;
  logic ss_prev_q;
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      sck_prev_q <= 1'b0;
      ss_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= i_pin_in;
      pin_sync_q <= pin_meta_q;
      sck_prev_q <= pin_sync_q[qss_pkg::PIN_SCK];
      ss_prev_q <= pin_sync_q[qss_pkg::PIN_PERIPH_SELECT_ZERO];
    end
  end
  wire ss_low = !pin_sync_q[qss_pkg::PIN_PERIPH_SELECT_ZERO];
  wire ss_fall = ss_prev_q && ss_low;
  wire s_rise = !sck_prev_q && pin_sync_q[qss_pkg::PIN_SCK];
  wire s_fall = sck_prev_q && !pin_sync_q[qss_pkg::PIN_SCK];

  // ****************************************
  // Sequencer
  // ****************************************
  qss_pkg::qss_state_t state_q;
  qss_pkg::qss_state_t state_d;
  logic [PW-1:0] work_q;
  logic [PW-1:0] work_d;
  logic [PW-1:0] cpt_q;
  logic [PW-1:0] start_act_q;
  logic [PW-1:0] end_act_q;
  logic [PW-1:0] start_pend_q;
  logic [PW-1:0] end_pend_q;
  logic pend_q;
  logic done_q;
  logic fault_q;
  logic [LW-1:0] len_q;
  logic [LW-1:0] bit_cnt_q;
  logic [WW-1:0] tx_sh_q;
  logic [WW-1:0] rx_sh_q;
  logic [7:0] div_cnt_q;
  logic sck_q;
  logic [qss_pkg::CMD_PCS_W-1:0] pcs_q;
  logic cs_act_q;
  logic cont_q;
  wire fifo_in_ready;

  wire en = i_port_enable_bit;
  wire master = i_master_select_bit;
  wire [qss_pkg::CMD_W-1:0] cmd_cur = cmd_mem_q[work_q];
  wire [LW-1:0] len_cur = len_of(master ? cmd_cur[qss_pkg::CMD_BITSE_BIT] : 1'b1,
                                 i_bits_field);
  wire [7:0] half = (i_baud_div < qss_pkg::DIV_MIN) ? qss_pkg::DIV_MIN : i_baud_div;
  wire tick = (state_q == qss_pkg::ST_XFER) && (div_cnt_q == half - qss_pkg::DIV_STEP);
  wire m_rise = master && tick && !sck_q;
  wire m_fall = master && tick && sck_q;
  wire smp = m_rise || (!master && s_rise);
  wire shf = m_fall || (!master && s_fall);
  wire [LW-1:0] cnt_next = bit_cnt_q + LW'(smp);
  wire m_end = m_fall && (bit_cnt_q == len_q);
  wire s_end = !master && ((s_fall && bit_cnt_q == len_q) || !ss_low);
  wire xfer_end = (state_q == qss_pkg::ST_XFER) && (m_end || s_end);
  wire hit = (work_q == end_act_q);
  wire wrap_on = i_wrap_enable_bit;
  wire start_ok = fifo_in_ready && (master || ss_fall);
  wire at_edge = (state_q == qss_pkg::ST_IDLE) || (state_q == qss_pkg::ST_HALT) ||
                 (state_q == qss_pkg::ST_STORE);
  wire ptr_apply = pend_q && at_edge;
  wire done_set = (state_q == qss_pkg::ST_STORE) && hit;
  wire fault_set = en && master && !i_periph_select_zero_is_output && ss_low;
  wire [PW-1:0] wrap_ptr = i_wrap_target_bit ? start_act_q : qss_pkg::PTR_RESET;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      qss_pkg::ST_IDLE: if (en) state_d = qss_pkg::ST_WAIT;
      qss_pkg::ST_WAIT: if (start_ok) state_d = qss_pkg::ST_LOAD;
      qss_pkg::ST_LOAD: state_d = qss_pkg::ST_XFER;
      qss_pkg::ST_XFER: if (xfer_end) state_d = qss_pkg::ST_STORE;
      qss_pkg::ST_STORE: state_d = (hit && !wrap_on) ? qss_pkg::ST_HALT : qss_pkg::ST_WAIT;
      qss_pkg::ST_HALT: state_d = qss_pkg::ST_HALT;
    endcase
    if (!en) begin
      state_d = qss_pkg::ST_IDLE;
    end
  end

  always_comb begin
    work_d = work_q;
    if (state_q == qss_pkg::ST_IDLE) begin
      work_d = start_act_q;
    end else if (state_q == qss_pkg::ST_STORE) begin
      work_d = hit ? wrap_ptr : work_q + qss_pkg::PTR_STEP;
    end
    if (ptr_apply) begin
      work_d = start_pend_q;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= qss_pkg::ST_IDLE;
      work_q <= qss_pkg::PTR_RESET;
      cpt_q <= qss_pkg::PTR_RESET;
      start_act_q <= qss_pkg::PTR_RESET;
      end_act_q <= qss_pkg::PTR_RESET;
      start_pend_q <= qss_pkg::PTR_RESET;
      end_pend_q <= qss_pkg::PTR_RESET;
      pend_q <= 1'b0;
      done_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      state_q <= state_d;
      work_q <= work_d;
      if (state_q == qss_pkg::ST_STORE) begin
        cpt_q <= work_q;
      end
      if (i_ptr_wr) begin
        start_pend_q <= i_queue_start_pointer;
        end_pend_q <= i_queue_end_pointer;
      end
      pend_q <= i_ptr_wr || (pend_q && !ptr_apply);
      if (ptr_apply) begin
        start_act_q <= start_pend_q;
        end_act_q <= end_pend_q;
      end
      done_q <= done_set || (done_q && !i_clr_done);
      fault_q <= fault_set || (fault_q && !i_clr_fault);
    end
  end

  // ****************************************
  // Shifter and serial clock
  // ****************************************
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      len_q <= qss_pkg::LEN_DEFAULT;
      bit_cnt_q <= '0;
      tx_sh_q <= '0;
      rx_sh_q <= '0;
      div_cnt_q <= '0;
      sck_q <= 1'b0;
    end else if (state_q == qss_pkg::ST_LOAD) begin
      len_q <= len_cur;
      bit_cnt_q <= '0;
      // Copy only; the stored word stays for the next wrap pass
      tx_sh_q <= tx_mem_q[work_q] << (LW'(WW) - len_cur);
      rx_sh_q <= '0;
      div_cnt_q <= '0;
      sck_q <= 1'b0;
    end else if (state_q == qss_pkg::ST_XFER) begin
      div_cnt_q <= tick ? '0 : div_cnt_q + qss_pkg::DIV_STEP;
      if (tick) begin
        sck_q <= !sck_q;
      end
      if (smp) begin
        rx_sh_q <= {rx_sh_q[WW-2:0],
                    master ? pin_sync_q[qss_pkg::PIN_MISO] : pin_sync_q[qss_pkg::PIN_MOSI]};
      end
      if (shf) begin
        tx_sh_q <= {tx_sh_q[WW-2:0], 1'b0};
      end
      bit_cnt_q <= cnt_next;
    end
  end

  // ****************************************
  // Receive fifo
  // ****************************************
  qss_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_in_valid(state_q == qss_pkg::ST_STORE),
    .o_in_ready(fifo_in_ready),
    .i_in_data({work_q, rx_sh_q}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  // ****************************************
  // Chip selects and pin drivers
  // ****************************************
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      pcs_q <= '0;
      cs_act_q <= 1'b0;
      cont_q <= 1'b0;
    end else if (!en || !master) begin
      cs_act_q <= 1'b0;
    end else if (state_q == qss_pkg::ST_LOAD) begin
      pcs_q <= cmd_cur[qss_pkg::CMD_PCS_LSB +: qss_pkg::CMD_PCS_W];
      cont_q <= cmd_cur[qss_pkg::CMD_CONT_BIT];
      cs_act_q <= 1'b1;
    end else if (state_q == qss_pkg::ST_STORE || state_q == qss_pkg::ST_HALT) begin
      cs_act_q <= cont_q && state_q == qss_pkg::ST_STORE;
    end
  end

  logic [qss_pkg::PIN_N-1:0] ser_out;
  logic [qss_pkg::PIN_N-1:0] ser_oe;
  wire [qss_pkg::PIN_N-1:0] pcs_pins = {pcs_q, 3'h0};
  always_comb begin
    ser_out = i_gpio_out;
    ser_oe = i_gpio_dir;
    if (master) begin
      ser_out[qss_pkg::PIN_MOSI] = tx_sh_q[WW-1];
      // A frame cut by disable can leave the divider high; park the clock outside frames
      ser_out[qss_pkg::PIN_SCK] = sck_q && (state_q == qss_pkg::ST_XFER);
      ser_oe[qss_pkg::PIN_MISO] = 1'b0;
      ser_oe[qss_pkg::PIN_MOSI] = 1'b1;
      ser_oe[qss_pkg::PIN_SCK] = 1'b1;
      ser_oe[qss_pkg::PIN_PERIPH_SELECT_ZERO] = i_periph_select_zero_is_output;
      if (cs_act_q) begin
        ser_out[qss_pkg::PIN_N-1:qss_pkg::PIN_PERIPH_SELECT_ZERO] =
          pcs_pins[qss_pkg::PIN_N-1:qss_pkg::PIN_PERIPH_SELECT_ZERO];
      end
    end else begin
      ser_out[qss_pkg::PIN_MISO] = tx_sh_q[WW-1];
      ser_oe[qss_pkg::PIN_MISO] = 1'b1;
      ser_oe[qss_pkg::PIN_MOSI] = 1'b0;
      ser_oe[qss_pkg::PIN_SCK] = 1'b0;
      ser_oe[qss_pkg::PIN_PERIPH_SELECT_ZERO] = 1'b0;
    end
  end

  logic [qss_pkg::PIN_N-1:0] pin_out_q;
  logic [qss_pkg::PIN_N-1:0] pin_oe_q;
  logic busy_q;
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
      busy_q <= 1'b0;
    end else begin
      // Disabled port hands every pin back to general-purpose I/O
      pin_out_q <= en ? ser_out : i_gpio_out;
      pin_oe_q <= en ? ser_oe : i_gpio_dir;
      busy_q <= (state_d != qss_pkg::ST_IDLE) && (state_d != qss_pkg::ST_HALT);
    end
  end

  assign o_rx_rdata = rx_rdata_q;
  assign o_queue_done_flag = done_q;
  assign o_mode_fault_flag = fault_q;
  assign o_completed_entry_pointer = cpt_q;
  assign o_active_start_pointer = start_act_q;
  assign o_active_end_pointer = end_act_q;
  assign o_busy = busy_q;
  assign o_pin_out = pin_out_q;
  assign o_pin_oe = pin_oe_q;
  assign o_gpio_in = pin_sync_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  chk_tx_read_only: assert property (
    !(i_mem_we && i_mem_seg == qss_pkg::SEG_TX) |=> $stable(tx_mem_q[0]))
    else $error("transmit word changed without a software write");
  chk_done_on_end: assert property (
    state_q == qss_pkg::ST_STORE && work_q == end_act_q |=> done_q && cpt_q == end_act_q)
    else $error("end entry completed without done flag");
  chk_cpt_copy: assert property (
    state_q == qss_pkg::ST_STORE |=> cpt_q == $past(work_q))
    else $error("completed pointer not copied from working pointer");
  chk_work_step: assert property (
    state_q == qss_pkg::ST_STORE && !hit && !pend_q |=> work_q == $past(work_q) + PW'(1))
    else $error("working pointer did not step by one");
  chk_fault_set: assert property (
    fault_set |=> fault_q)
    else $error("mode fault not flagged");
  chk_fault_drivers: assert property (
    en && master && fault_q |=> pin_oe_q[qss_pkg::PIN_MOSI] && pin_oe_q[qss_pkg::PIN_SCK])
    else $error("drivers dropped on mode fault");
  chk_halt_no_wrap: assert property (
    state_q == qss_pkg::ST_STORE && hit && !wrap_on && en |=> state_q == qss_pkg::ST_HALT
    ##1 !busy_q)
    else $error("queue did not halt at end entry");
  chk_wrap_target: assert property (
    state_q == qss_pkg::ST_STORE && hit && wrap_on && !pend_q |=>
    work_q == ($past(i_wrap_target_bit) ? start_act_q : qss_pkg::PTR_RESET))
    else $error("wrap went to the wrong entry");
  chk_ptr_buffered: assert property (
    state_q == qss_pkg::ST_XFER && state_d == qss_pkg::ST_XFER |=> $stable(start_act_q))
    else $error("active start pointer changed mid transfer");
  chk_flag_sticky: assert property (
    done_q && !i_clr_done |=> done_q)
    else $error("done flag dropped without clear");
  cov_done: cover property (state_q == qss_pkg::ST_STORE && hit ##1 done_q);
  cov_wrap: cover property (state_q == qss_pkg::ST_STORE && hit && wrap_on);
  cov_fault: cover property ($rose(fault_q));
  cov_slave: cover property (!master && state_q == qss_pkg::ST_STORE);
endmodule : qss_top

// ==== verification/qss_periph_model.sv ====
`timescale 1ns/1ns
// ********
// Peripheral on the far side: mode 0, MSB first
// ********
module qss_periph_model (
  // Wire levels
  input wire logic i_sel_n,
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic [2:0] i_upper,
  input wire logic [15:0] i_reply,
  // Observations
  output logic o_miso,
  output logic [15:0] o_got,
  output logic [2:0] o_upper,
  output logic [7:0] o_count
);
  logic [15:0] sh_q = 16'h0000;
  initial begin
    o_got = 16'h0000;
    o_upper = 3'h0;
    o_count = 8'h00;
  end
  // Deselected, the line floats up through its pull-up
  assign o_miso = i_sel_n ? 1'b1 : sh_q[15];
  always @(negedge i_sel_n) begin
    sh_q = i_reply;
    o_got = 16'h0000;
    o_upper = i_upper;
    o_count = o_count + 8'h01;
  end
  always @(posedge i_sck) begin
    if (!i_sel_n) begin
      o_got = {o_got[14:0], i_mosi};
    end
  end
  // Next bit only after the master has sampled this one
  always @(negedge i_sck) begin
    if (!i_sel_n) begin
      sh_q = {sh_q[14:0], 1'b0};
    end
  end
endmodule : qss_periph_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  logic clk = 1'b0;
  logic reset, en, master_select_bit, wrap_enable_bit, wrap_target_bit, periph_select_zero_out, ptr_wr, clr_done, clr_fault, we, seg, rd;
  logic [3:0] bits_field, start_p, end_p, idx, rx_idx, cpt, act_s, act_e;
  logic [15:0] wdata, rx_rdata, got;
  logic done, fault, busy, miso_m;
  logic [6:0] ext, gdir, pout, poe, gin, pin_in, s_oe;
  logic [7:0] cnt, c0, sbyte;
  logic [2:0] up;
  int err_count = 0;
  int checks_done = 0;
  assign pin_in[6:1] = (poe[6:1] & pout[6:1]) | (~poe[6:1] & ext[6:1]);
  assign pin_in[0] = poe[0] ? pout[0] : miso_m;
  qss_top dut (.i_sys_clk(clk), .i_reset(reset), .i_port_enable_bit(en),
    .i_master_select_bit(master_select_bit), .i_wrap_enable_bit(wrap_enable_bit), .i_wrap_target_bit(wrap_target_bit),
    .i_periph_select_zero_is_output(periph_select_zero_out), .i_bits_field(bits_field), .i_baud_div(8'h04),
    .i_ptr_wr(ptr_wr), .i_queue_start_pointer(start_p), .i_queue_end_pointer(end_p),
    .i_clr_done(clr_done), .i_clr_fault(clr_fault), .i_mem_we(we), .i_mem_seg(seg),
    .i_mem_idx(idx), .i_mem_wdata(wdata), .i_rx_rd_en(rd), .i_rx_rd_idx(rx_idx),
    .o_rx_rdata(rx_rdata), .o_queue_done_flag(done), .o_mode_fault_flag(fault),
    .o_completed_entry_pointer(cpt), .o_active_start_pointer(act_s),
    .o_active_end_pointer(act_e), .o_busy(busy), .i_pin_in(pin_in), .i_gpio_out(7'h7F),
    .i_gpio_dir(gdir), .o_pin_out(pout), .o_pin_oe(poe), .o_gpio_in(gin));
  qss_periph_model u_model (.i_sel_n(pin_in[3] | ~master_select_bit), .i_sck(pin_in[2]),
    .i_mosi(pin_in[1]), .i_upper(pin_in[6:4]), .i_reply(16'hC35A), .o_miso(miso_m),
    .o_got(got), .o_upper(up), .o_count(cnt));
  initial begin
    forever #5 clk = ~clk;
  end
  // ********
  // Access tasks
  // ********
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic wr_mem(input logic s, input logic [3:0] i, input logic [15:0] d);
    tick(1);
    {we, seg, idx, wdata} = {1'b1, s, i, d};
    tick(1);
    we = 1'b0;
  endtask : wr_mem
  task automatic set_ptr(input logic [3:0] s, input logic [3:0] e);
    tick(1);
    {ptr_wr, start_p, end_p} = {1'b1, s, e};
    tick(1);
    ptr_wr = 1'b0;
    tick(2);
    `CHK("active_start", s, act_s)
    `CHK("active_end", e, act_e)
  endtask : set_ptr
  task automatic chk_rx(input logic [3:0] i, input logic [15:0] e);
    tick(1);
    {rd, rx_idx} = {1'b1, i};
    tick(1);
    rd = 1'b0;
    `CHK("rx_word", e, rx_rdata)
  endtask : chk_rx
  task automatic clr();
    tick(1);
    {clr_done, clr_fault} = 2'b11;
    tick(1);
    {clr_done, clr_fault} = 2'b00;
    tick(1);
  endtask : clr
  task automatic wait_done();
    for (int i = 0; i < 4000 && done !== 1'b1; i++) tick(1);
    `CHK("done_flag", 1'b1, done)
  endtask : wait_done
  task automatic run_q();
    tick(1);
    en = 1'b1;
    wait_done();
    en = 1'b0;
    tick(8);
  endtask : run_q
  // Link clock of 160 ns made only while selected
  task automatic slave_xfer(input logic [7:0] m, output logic [7:0] s);
    tick(1);
    ext[3] = 1'b0;
    tick(8);
    for (int b = 7; b >= 0; b--) begin
      ext[1] = m[b];
      tick(8);
      ext[2] = 1'b1;
      tick(7);
      s[b] = pin_in[0];
      s_oe = poe;
      tick(1);
      ext[2] = 1'b0;
    end
    tick(8);
    ext[3] = 1'b1;
  endtask : slave_xfer
  task automatic test_done();
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  // ********
  // Scenarios
  // ********
  initial begin
    {en, master_select_bit, wrap_enable_bit, wrap_target_bit, ptr_wr, clr_done, clr_fault, we, seg, rd} = '0;
    {bits_field, start_p, end_p, idx, rx_idx} = '0;
    // Link clock rests low as in mode 0, so the first slave rise is a real edge
    {reset, periph_select_zero_out, wdata, ext, gdir} = {2'b11, 16'h0000, 7'h7B, 7'h78};
    tick(16);
    reset = 1'b0;
    tick(2);
    `CHK("reset_start", 4'h0, act_s)
    `CHK("reset_end", 4'h0, act_e)
    `CHK("reset_flags", 2'b00, {done, fault})
    master_select_bit = 1'b1;
    wr_mem(qss_pkg::SEG_CMD, 4'h0, 16'h000E);
    wr_mem(qss_pkg::SEG_TX, 4'h0, 16'h00A5);
    for (int k = 0; k < 2; k++) begin
      c0 = cnt;
      run_q();
      `CHK("xfer_count", c0 + 8'h01, cnt)
      `CHK("sent_word", 16'h00A5, got)
      `CHK("completed", 4'h0, cpt)
      chk_rx(4'h0, 16'h00C3);
      `CHK("done_sticky", 1'b1, done)
      clr();
      `CHK("done_clear", 1'b0, done)
    end
    // Entry F holds its select, so entry 0 runs inside the same selection
    wr_mem(qss_pkg::SEG_CMD, 4'hF, 16'h008A);
    wr_mem(qss_pkg::SEG_TX, 4'hF, 16'h0081);
    wr_mem(qss_pkg::SEG_CMD, 4'h1, 16'h004A);
    wr_mem(qss_pkg::SEG_TX, 4'h1, 16'hBEEF);
    set_ptr(4'hF, 4'h1);
    c0 = cnt;
    run_q();
    `CHK("queue_count", c0 + 8'h02, cnt)
    `CHK("completed", 4'h1, cpt)
    `CHK("last_word", 16'hBEEF, got)
    `CHK("upper_select", 3'h5, up)
    chk_rx(4'hF, 16'h00C3);
    chk_rx(4'h1, 16'hC35A);
    chk_rx(4'h0, 16'h005A);
    clr();
    wr_mem(qss_pkg::SEG_CMD, 4'h2, 16'h000E);
    wr_mem(qss_pkg::SEG_CMD, 4'h3, 16'h000E);
    set_ptr(4'h2, 4'h3);
    for (int t = 0; t < 2; t++) begin
      {wrap_enable_bit, wrap_target_bit, en} = {1'b1, t == 1, 1'b1};
      wait_done();
      for (int i = 0; i < 2000 && cpt === 4'h3; i++) tick(1);
      `CHK("wrap_target", t ? 4'h2 : 4'h0, cpt)
      {wrap_enable_bit, en} = 2'b00;
      tick(8);
      clr();
    end
    {gdir, periph_select_zero_out} = {7'h70, 1'b0};
    set_ptr(4'h0, 4'h0);
    en = 1'b1;
    tick(2);
    ext[3] = 1'b0;
    tick(4);
    `CHK("fault", 1'b1, fault)
    `CHK("master_oe", 3'h6, poe[2:0])
    {ext[3], en} = 2'b10;
    tick(8);
    `CHK("fault_sticky", 1'b1, fault)
    `CHK("gpio_oe", gdir, poe)
    clr();
    `CHK("fault_clear", 1'b0, fault)
    {master_select_bit, gdir, bits_field} = {1'b0, 7'h00, 4'h8};
    wr_mem(qss_pkg::SEG_TX, 4'h5, 16'h0096);
    set_ptr(4'h5, 4'h5);
    en = 1'b1;
    tick(4);
    `CHK("slave_busy", 1'b1, busy)
    slave_xfer(8'h3C, sbyte);
    `CHK("slave_out", 8'h96, sbyte)
    `CHK("slave_oe", 7'h01, s_oe)
    wait_done();
    `CHK("completed", 4'h5, cpt)
    en = 1'b0;
    tick(8);
    chk_rx(4'h5, 16'h003C);
    `CHK("gpio_in", 7'h79, gin)
    test_done();
  end
  initial begin
    #500000;
    err_count++;
    test_done();
  end
endmodule : testbench
